// ---- pllsib_bank.sv ----
// How it works
// R1 - Synth PLL unlock latched and enabled drives interrupt low.
// R2 - VCXO PLL unlock latched and enabled drives interrupt low.
// R3 - Each input's latched signal loss, when enabled, drives interrupt low.
// R4 - Any reference-valid change, when enabled, drives interrupt low.
// R5 - Latched holdover entry, when enabled, drives interrupt low.
// R6 - Enables reset to zero; disabled flags still latch, never interrupt.
// R7 - Synth lock latch reads 0 after any unlock since clear.
// R8 - Writing 1 clears synth lock latch and its interrupt.
// R9 - VCXO lock latch reads 0 after any unlock since clear.
// R10 - Writing 1 clears VCXO lock latch and its interrupt.
// R11 - Input signal latch reads 0 after any loss since clear.
// R12 - Writing 1 clears input signal latch and its interrupt.
// R13 - Two-bit selection field shows chosen input, 00 or 01.
// R14 - Live lock bits read 0 while unlocked, 1 otherwise.
// R15 - Live signal bits read 0 during loss, 1 while active.
// R16 - Reference latch reads 0 after loss; write 1 clears it.
// R17 - Holdover latch reads 0 after holdover entry; write 1 clears.
// R18 - Live holdover reads 0 in holdover; live reference 1 when present.
// R19 - Calibration bit reads 1 while calibrating, 0 when done.
// R20 - Interrupt low while any enabled flag pends, high once all cleared.
// R21 - Latches sample on device clock; event beats simultaneous clear.
`timescale 1ns/1ps
`default_nettype none

module pllsib_bank (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Register access from the serial port logic
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  // Raw conditions from the monitors
  input wire logic i_synth_pll_lock_n,
  input wire logic i_vcxo_pll_lock_n,
  input wire logic i_input0_signal,
  input wire logic i_input1_signal,
  input wire logic i_reference_present,
  input wire logic i_holdover_n,
  input wire logic i_synth_cal_active,
  input wire logic [1:0] i_selected_input_state,
  // Interrupt
  output logic o_irq_out_n
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // Monitors run off other clocks, so every condition is resynchronised and
  // a new level is only accepted once the second and third stages agree.
  logic [pllsib_pkg::NUM_SYNC-1:0] raw_vec;
  logic [pllsib_pkg::NUM_SYNC-1:0] live_reg;
  logic [pllsib_pkg::NUM_SYNC-1:0] live_next;

  assign raw_vec = {i_selected_input_state, i_synth_cal_active, i_reference_present,
                    i_holdover_n, i_synth_pll_lock_n, i_vcxo_pll_lock_n,
                    i_input1_signal, i_input0_signal};

  genvar gs;
  generate
    for (gs = 0; gs < pllsib_pkg::NUM_SYNC; gs = gs + 1) begin : g_sync
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      // R21 clocked capture
      always_comb begin
        if (s2_reg == s3_reg) begin
          live_next[gs] = s3_reg;
        end else begin
          live_next[gs] = live_reg[gs];
        end
      end

      always_ff @(posedge i_clock) begin
        if (i_rst) begin
          s1_reg <= pllsib_pkg::RST_SYNC[gs];
          s2_reg <= pllsib_pkg::RST_SYNC[gs];
          s3_reg <= pllsib_pkg::RST_SYNC[gs];
          live_reg[gs] <= pllsib_pkg::RST_SYNC[gs];
        end else begin
          s1_reg <= raw_vec[gs];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          live_reg[gs] <= live_next[gs];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Enable registers
  // ----------------------------------------
  logic [7:0] ie_lock_clock_reg;
  logic [7:0] ie_lock_clock_next;
  logic [7:0] ref_change_irq_en_hold_reg;
  logic [7:0] ref_change_irq_en_hold_next;
  logic wr_ie_lock_clock;
  logic wr_ref_change_irq_en_hold;
  logic wr_latched_lock_clock;
  logic wr_latched_ref_hold;

  assign wr_ie_lock_clock = i_reg_wr && (i_reg_addr == pllsib_pkg::OFS_LOCK_CLOCK_IRQ_ENABLE);
  assign wr_ref_change_irq_en_hold = i_reg_wr && (i_reg_addr == pllsib_pkg::OFS_REF_HOLDOVER_IRQ_ENABLE);
  assign wr_latched_lock_clock = i_reg_wr && (i_reg_addr == pllsib_pkg::OFS_LOCK_CLOCK_LATCHED_STATUS);
  assign wr_latched_ref_hold = i_reg_wr && (i_reg_addr == pllsib_pkg::OFS_REF_HOLDOVER_LATCHED_STATUS);

  always_comb begin
    ie_lock_clock_next = ie_lock_clock_reg;
    ref_change_irq_en_hold_next = ref_change_irq_en_hold_reg;
    if (wr_ie_lock_clock) begin
      ie_lock_clock_next = i_reg_wdata & pllsib_pkg::MASK_LOCK_CLOCK_IRQ_ENABLE;
    end
    if (wr_ref_change_irq_en_hold) begin
      ref_change_irq_en_hold_next = i_reg_wdata & pllsib_pkg::MASK_REF_HOLDOVER_IRQ_ENABLE;
    end
  end

  // R6 enables reset to zero
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ie_lock_clock_reg <= pllsib_pkg::RST_IRQ_ENABLE;
      ref_change_irq_en_hold_reg <= pllsib_pkg::RST_IRQ_ENABLE;
    end else begin
      ie_lock_clock_reg <= ie_lock_clock_next;
      ref_change_irq_en_hold_reg <= ref_change_irq_en_hold_next;
    end
  end

  // ----------------------------------------
  // Sticky event flags
  // ----------------------------------------
  logic [pllsib_pkg::NUM_FLAG-1:0] flag_set;
  logic [pllsib_pkg::NUM_FLAG-1:0] flag_clear;
  logic [pllsib_pkg::NUM_FLAG-1:0] flag_vec;
  logic [pllsib_pkg::NUM_FLAG-1:0] flag_en;

  // R7 R9 R11 R16 R17 event while live low
  always_comb begin
    flag_set[pllsib_pkg::IDX_REF:0] = ~live_reg[pllsib_pkg::IDX_REF:0];
    // R4 either direction of reference validity
    flag_set[pllsib_pkg::IDX_REFCHG] = live_next[pllsib_pkg::IDX_REF] != live_reg[pllsib_pkg::IDX_REF];
  end

  // R8 R10 R12 R16 R17 write one to clear
  always_comb begin
    flag_clear[pllsib_pkg::IDX_CLK0] = wr_latched_lock_clock && i_reg_wdata[pllsib_pkg::BIT_CLK0];
    flag_clear[pllsib_pkg::IDX_CLK1] = wr_latched_lock_clock && i_reg_wdata[pllsib_pkg::BIT_CLK1];
    flag_clear[pllsib_pkg::IDX_VCXO] = wr_latched_lock_clock && i_reg_wdata[pllsib_pkg::BIT_VCXO];
    flag_clear[pllsib_pkg::IDX_SYNTH] = wr_latched_lock_clock && i_reg_wdata[pllsib_pkg::BIT_SYNTH];
    flag_clear[pllsib_pkg::IDX_HOLD] = wr_latched_ref_hold && i_reg_wdata[pllsib_pkg::BIT_HOLD];
    flag_clear[pllsib_pkg::IDX_REF] = wr_latched_ref_hold && i_reg_wdata[pllsib_pkg::BIT_REF];
    flag_clear[pllsib_pkg::IDX_REFCHG] = wr_latched_ref_hold && i_reg_wdata[pllsib_pkg::BIT_REF];
  end

  genvar gf;
  generate
    for (gf = 0; gf < pllsib_pkg::NUM_FLAG; gf = gf + 1) begin : g_flag
      pllsib_sticky u_sticky (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_set(flag_set[gf]),
        .i_clear(flag_clear[gf]),
        .o_flag(flag_vec[gf])
      );
    end
  endgenerate

  // ----------------------------------------
  // Interrupt output
  // ----------------------------------------
  // Loss of reference alone does not interrupt; its change flag does.
  always_comb begin
    // R1 R2 R3 R5 per-condition enables
    flag_en[pllsib_pkg::IDX_CLK0] = ie_lock_clock_reg[pllsib_pkg::BIT_CLK0];
    flag_en[pllsib_pkg::IDX_CLK1] = ie_lock_clock_reg[pllsib_pkg::BIT_CLK1];
    flag_en[pllsib_pkg::IDX_VCXO] = ie_lock_clock_reg[pllsib_pkg::BIT_VCXO];
    flag_en[pllsib_pkg::IDX_SYNTH] = ie_lock_clock_reg[pllsib_pkg::BIT_SYNTH];
    flag_en[pllsib_pkg::IDX_HOLD] = ref_change_irq_en_hold_reg[pllsib_pkg::BIT_HOLD];
    flag_en[pllsib_pkg::IDX_REF] = 1'b0;
    flag_en[pllsib_pkg::IDX_REFCHG] = ref_change_irq_en_hold_reg[pllsib_pkg::BIT_REF];
  end

  logic irq_reg;
  logic irq_next;

  // R20 low while any enabled flag pends
  always_comb begin
    irq_next = ~|(flag_vec & flag_en);
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      irq_reg <= 1'b1;
    end else begin
      irq_reg <= irq_next;
    end
  end

  assign o_irq_out_n = irq_reg;

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [7:0] rmux;

  always_comb begin
    rmux = 8'h00;
    case (i_reg_addr)
      pllsib_pkg::OFS_LOCK_CLOCK_IRQ_ENABLE: begin
        rmux = ie_lock_clock_reg;
      end
      pllsib_pkg::OFS_REF_HOLDOVER_IRQ_ENABLE: begin
        rmux = ref_change_irq_en_hold_reg;
      end
      pllsib_pkg::OFS_LOCK_CLOCK_LATCHED_STATUS: begin
        // R7 R9 R11 latch reads low after event
        rmux[pllsib_pkg::BIT_CLK0] = ~flag_vec[pllsib_pkg::IDX_CLK0];
        rmux[pllsib_pkg::BIT_CLK1] = ~flag_vec[pllsib_pkg::IDX_CLK1];
        rmux[pllsib_pkg::BIT_VCXO] = ~flag_vec[pllsib_pkg::IDX_VCXO];
        rmux[pllsib_pkg::BIT_SYNTH] = ~flag_vec[pllsib_pkg::IDX_SYNTH];
      end
      pllsib_pkg::OFS_LOCK_CLOCK_LIVE_STATUS: begin
        // R13 R14 R15 live lock, signal, selection
        rmux[pllsib_pkg::BIT_CLK0] = live_reg[pllsib_pkg::IDX_CLK0];
        rmux[pllsib_pkg::BIT_CLK1] = live_reg[pllsib_pkg::IDX_CLK1];
        rmux[pllsib_pkg::BIT_VCXO] = live_reg[pllsib_pkg::IDX_VCXO];
        rmux[pllsib_pkg::BIT_SYNTH] = live_reg[pllsib_pkg::IDX_SYNTH];
        rmux[pllsib_pkg::BIT_SEL_LO +: 2] = live_reg[pllsib_pkg::IDX_SEL_LO +: 2];
      end
      pllsib_pkg::OFS_REF_HOLDOVER_LATCHED_STATUS: begin
        // R16 R17 reference and holdover latches
        rmux[pllsib_pkg::BIT_HOLD] = ~flag_vec[pllsib_pkg::IDX_HOLD];
        rmux[pllsib_pkg::BIT_REF] = ~flag_vec[pllsib_pkg::IDX_REF];
      end
      pllsib_pkg::OFS_REF_HOLDOVER_CAL_LIVE_STATUS: begin
        // R18 R19 live holdover, reference, calibration
        rmux[pllsib_pkg::BIT_HOLD] = live_reg[pllsib_pkg::IDX_HOLD];
        rmux[pllsib_pkg::BIT_REF] = live_reg[pllsib_pkg::IDX_REF];
        rmux[pllsib_pkg::BIT_CAL] = live_reg[pllsib_pkg::IDX_CAL];
      end
      default: begin
        rmux = 8'h00;
      end
    endcase
  end

  // Reads have no side effect; data holds until the next read
  always_comb begin
    rdata_next = i_reg_rd ? rmux : rdata_reg;
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rdata_reg <= pllsib_pkg::RST_READ_DATA;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign o_reg_rdata = rdata_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  logic rd_live_a;
  logic rd_live_b;
  assign rd_live_a = i_reg_rd && (i_reg_addr == pllsib_pkg::OFS_LOCK_CLOCK_LIVE_STATUS);
  assign rd_live_b = i_reg_rd && (i_reg_addr == pllsib_pkg::OFS_REF_HOLDOVER_CAL_LIVE_STATUS);
  logic rd_latched_a;
  logic rd_latched_b;
  assign rd_latched_a = i_reg_rd && (i_reg_addr == pllsib_pkg::OFS_LOCK_CLOCK_LATCHED_STATUS);
  assign rd_latched_b = i_reg_rd && (i_reg_addr == pllsib_pkg::OFS_REF_HOLDOVER_LATCHED_STATUS);

  a_irq_synth_unlock: assert property (flag_vec[3] && ie_lock_clock_reg[5] |=> !o_irq_out_n) // R1
    else $error("synth unlock did not interrupt");
  a_irq_vcxo_unlock: assert property (flag_vec[2] && ie_lock_clock_reg[4] |=> !o_irq_out_n) // R2
    else $error("vcxo unlock did not interrupt");
  a_irq_input_los: assert property ((flag_vec[0] && ie_lock_clock_reg[0]) ||
                                    (flag_vec[1] && ie_lock_clock_reg[1]) |=> !o_irq_out_n) // R3
    else $error("input loss did not interrupt");
  a_irq_ref_change: assert property ($changed(live_reg[5]) && ref_change_irq_en_hold_reg[1] |=> !o_irq_out_n) // R4
    else $error("reference change did not interrupt");
  a_irq_holdover_entry: assert property (flag_vec[4] && ref_change_irq_en_hold_reg[0] |=> !o_irq_out_n) // R5
    else $error("holdover did not interrupt");
  a_irq_masked_quiet: assert property (~|(flag_vec & flag_en) |=> o_irq_out_n) // R6
    else $error("interrupt without enabled flag");
  a_enable_reset_zero: assert property ($fell(i_rst) |-> ie_lock_clock_reg == 8'h00 && ref_change_irq_en_hold_reg == 8'h00) // R6
    else $error("enables not zero after reset");
  a_irq_has_cause: assert property (!o_irq_out_n |-> $past(|(flag_vec & flag_en))) // R20
    else $error("interrupt low with no pending cause");
  a_sel_readback: assert property (rd_live_a |=> o_reg_rdata[7:6] == $past(live_reg[8:7])) // R13
    else $error("selection field mismatch");
  a_lock_live_read: assert property (rd_live_a |=> o_reg_rdata[5:4] == $past(live_reg[3:2]) &&
                                     o_reg_rdata[1:0] == $past(live_reg[1:0])) // R14
    else $error("live lock or signal mismatch");
  a_cal_live_read: assert property (rd_live_b |=> o_reg_rdata[2:0] == $past(live_reg[6:4])) // R19
    else $error("cal, reference or holdover mismatch");
  a_synth_latch_read: assert property (i_reg_rd && i_reg_addr == pllsib_pkg::OFS_LOCK_CLOCK_LATCHED_STATUS
                                       |=> o_reg_rdata[5] == !$past(flag_vec[3])) // R7
    else $error("synth latch read wrong");
  // Remaining latched fields read back inverted, one cycle after the strobe
  a_vcxo_latch_read: assert property (rd_latched_a |=>
                                      o_reg_rdata[4] == !$past(flag_vec[2])) // R9
    else $error("vcxo latch read wrong");
  a_input_latch_read: assert property (rd_latched_a |=>
                                       o_reg_rdata[1:0] == ~$past(flag_vec[1:0])) // R11
    else $error("input signal latch read wrong");
  a_ref_hold_latch_read: assert property (rd_latched_b |=>
                                          o_reg_rdata[1:0] == ~$past(flag_vec[5:4])) // R16
    else $error("reference or holdover latch read wrong");

  // Write-one bits for synth, vcxo, input 1 and holdover must clear their latch; an event that cycle still wins
  a_synth_clear_takes: assert property (wr_latched_lock_clock && i_reg_wdata[5] && !flag_set[3]
                                        |=> !flag_vec[3]) // R8
    else $error("synth latch not cleared by write one");
  a_vcxo_clear_takes: assert property (wr_latched_lock_clock && i_reg_wdata[4] && !flag_set[2]
                                       |=> !flag_vec[2]) // R10
    else $error("vcxo latch not cleared by write one");
  a_input_clear_takes: assert property (wr_latched_lock_clock && i_reg_wdata[1] && !flag_set[1]
                                        |=> !flag_vec[1]) // R12
    else $error("input latch not cleared by write one");
  a_hold_clear_takes: assert property (wr_latched_ref_hold && i_reg_wdata[0] && !flag_set[4]
                                       |=> !flag_vec[4]) // R17
    else $error("holdover latch not cleared by write one");

  // Reserved enable bits never stick, so they can never unmask anything
  a_enable_write_masked: assert property (wr_ie_lock_clock |=>
                                          ie_lock_clock_reg == ($past(i_reg_wdata) & 8'h33)) // R6
    else $error("enable write not masked");

  c_irq_asserted: cover property ($fell(o_irq_out_n));
  c_clear_and_event: cover property (flag_set[3] && flag_clear[3]);
  c_ref_recovered: cover property ($rose(live_reg[5]) && ref_change_irq_en_hold_reg[1]);
  c_irq_released: cover property ($rose(o_irq_out_n));
  c_masked_event: cover property (flag_vec[3] && !ie_lock_clock_reg[5]);

endmodule

`default_nettype wire

// ---- pllsib_pkg.sv ----
package pllsib_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_LOCK_CLOCK_IRQ_ENABLE = 8'h68;
  localparam logic [7:0] OFS_REF_HOLDOVER_IRQ_ENABLE = 8'h69;
  localparam logic [7:0] OFS_LOCK_CLOCK_LATCHED_STATUS = 8'h6c;
  localparam logic [7:0] OFS_LOCK_CLOCK_LIVE_STATUS = 8'h6d;
  localparam logic [7:0] OFS_REF_HOLDOVER_LATCHED_STATUS = 8'h6e;
  localparam logic [7:0] OFS_REF_HOLDOVER_CAL_LIVE_STATUS = 8'h6f;

  // ----------------------------------------
  // Field positions (bit index in the byte)
  // ----------------------------------------
  localparam int BIT_CLK0 = 0;
  localparam int BIT_CLK1 = 1;
  localparam int BIT_VCXO = 4;
  localparam int BIT_SYNTH = 5;
  localparam int BIT_SEL_LO = 6;
  localparam int BIT_HOLD = 0;
  localparam int BIT_REF = 1;
  localparam int BIT_CAL = 2;

  // ----------------------------------------
  // Reset values and writable masks
  // ----------------------------------------
  localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
  localparam logic [7:0] MASK_LOCK_CLOCK_IRQ_ENABLE = 8'h33;
  localparam logic [7:0] MASK_REF_HOLDOVER_IRQ_ENABLE = 8'h03;
  localparam logic [7:0] RST_READ_DATA = 8'h00;

  // ----------------------------------------
  // Condition vectors
  // ----------------------------------------
  // Synchronised inputs: 0 clk0 signal, 1 clk1 signal, 2 vcxo lock_n,
  // 3 synth lock_n, 4 holdover_n, 5 reference present, 6 cal, 8:7 select
  localparam int NUM_SYNC = 9;
  localparam logic [8:0] RST_SYNC = 9'h03f;
  // Sticky flags: 0..5 as above (event = live low), 6 = reference change
  localparam int NUM_FLAG = 7;
  localparam int IDX_CLK0 = 0;
  localparam int IDX_CLK1 = 1;
  localparam int IDX_VCXO = 2;
  localparam int IDX_SYNTH = 3;
  localparam int IDX_HOLD = 4;
  localparam int IDX_REF = 5;
  localparam int IDX_REFCHG = 6;
  localparam int IDX_CAL = 6;
  localparam int IDX_SEL_LO = 7;

endpackage

// ---- pllsib_sticky.sv ----
`timescale 1ns/1ps
`default_nettype none

module pllsib_sticky (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Event and clear
  input wire logic i_set,
  input wire logic i_clear,
  // Sticky flag
  output logic o_flag
);

  logic flag_reg;
  logic flag_next;

  // ----------------------------------------
  // Latch
  // ----------------------------------------
  // R21 set beats clear
  always_comb begin
    if (i_set) begin
      flag_next = 1'b1;
    end else if (i_clear) begin
      flag_next = 1'b0;
    end else begin
      flag_next = flag_reg;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign o_flag = flag_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  a_set_wins_clear: assert property (i_set |=> o_flag) // R21
    else $error("event lost against clear");
  a_clear_drops_flag: assert property (i_clear && !i_set |=> !o_flag) // R8
    else $error("write one did not clear latch");
  a_flag_holds: assert property (o_flag && !i_clear |=> o_flag) // R7
    else $error("latched flag dropped without clear");

endmodule

`default_nettype wire

// ---- tb_pll_status_interrupt_bank.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_pll_status_interrupt_bank;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] i_reg_addr = 8'h00;
  logic i_reg_wr = 1'b0;
  logic [7:0] i_reg_wdata = 8'h00;
  logic i_reg_rd = 1'b0;
  logic [7:0] o_reg_rdata;
  logic o_irq_out_n;
  // Raw conditions: 0 synth lock_n, 1 vcxo lock_n, 2 in0, 3 in1, 4 ref, 5 hold_n, 6 cal, 8:7 sel
  logic [8:0] raw = 9'h03f;
  int fails = 0;
  int n_compared = 0;

  always #50 i_clock = ~i_clock;

  pllsib_bank uut (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_reg_addr(i_reg_addr),
    .i_reg_wr(i_reg_wr),
    .i_reg_wdata(i_reg_wdata),
    .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata),
    .i_synth_pll_lock_n(raw[0]),
    .i_vcxo_pll_lock_n(raw[1]),
    .i_input0_signal(raw[2]),
    .i_input1_signal(raw[3]),
    .i_reference_present(raw[4]),
    .i_holdover_n(raw[5]),
    .i_synth_cal_active(raw[6]),
    .i_selected_input_state(raw[8:7]),
    .o_irq_out_n(o_irq_out_n)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (fails == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Inputs move on the edge by NBA, outputs are looked at 1 ns later
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clock);
    i_reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clock);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clock);
    i_reg_rd <= 1'b0;
    #1;
    check(o_reg_rdata, exp);
  endtask

  task automatic irq_chk(input logic exp);
    check({7'h00, o_irq_out_n}, {7'h00, exp});
  endtask

  task automatic set_raw(input int idx, input logic v);
    @(posedge i_clock);
    raw[idx] <= v;
    cyc(8);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_and_access();
    rd_chk(8'h68, 8'h00);
    rd_chk(8'h69, 8'h00);
    rd_chk(8'h6c, 8'h33);
    rd_chk(8'h6e, 8'h03);
    rd_chk(8'h6d, 8'h33);
    rd_chk(8'h6f, 8'h03);
    irq_chk(1'b1);
    // Reserved bits must read back as zero
    wr(8'h68, 8'hff);
    rd_chk(8'h68, 8'h33);
    wr(8'h69, 8'hff);
    rd_chk(8'h69, 8'h03);
    irq_chk(1'b1);
    wr(8'h6d, 8'h00);
    rd_chk(8'h6d, 8'h33);
    wr(8'h6f, 8'hff);
    rd_chk(8'h6f, 8'h03);
    rd_chk(8'h70, 8'h00);
    wr(8'h68, 8'h00);
    wr(8'h69, 8'h00);
  endtask

  // One loss-of-lock or loss-of-signal condition, enabled or not
  task automatic t_lock_event(input int ri, input int b, input logic en);
    logic [7:0] m;
    m = 8'h01 << b;
    wr(8'h68, en ? m : 8'h00);
    set_raw(ri, 1'b0);
    rd_chk(8'h6d, 8'h33 & ~m);
    rd_chk(8'h6c, 8'h33 & ~m);
    irq_chk(~en);
    // Clear while the condition persists must not take
    wr(8'h6c, m);
    cyc(3);
    rd_chk(8'h6c, 8'h33 & ~m);
    irq_chk(~en);
    set_raw(ri, 1'b1);
    rd_chk(8'h6d, 8'h33);
    rd_chk(8'h6c, 8'h33 & ~m);
    irq_chk(~en);
    wr(8'h6c, m);
    cyc(3);
    rd_chk(8'h6c, 8'h33);
    irq_chk(1'b1);
    wr(8'h68, 8'h00);
  endtask

  // Interrupt stays low until the last enabled flag is cleared
  task automatic t_two_pending();
    wr(8'h68, 8'h30);
    @(posedge i_clock);
    raw[0] <= 1'b0;
    raw[1] <= 1'b0;
    cyc(8);
    @(posedge i_clock);
    raw[0] <= 1'b1;
    raw[1] <= 1'b1;
    cyc(8);
    wr(8'h6c, 8'h20);
    cyc(3);
    irq_chk(1'b0);
    rd_chk(8'h6c, 8'h23);
    wr(8'h6c, 8'h10);
    cyc(3);
    irq_chk(1'b1);
    rd_chk(8'h6c, 8'h33);
    wr(8'h68, 8'h00);
  endtask

  task automatic t_holdover();
    wr(8'h69, 8'h01);
    set_raw(5, 1'b0);
    rd_chk(8'h6f, 8'h02);
    rd_chk(8'h6e, 8'h02);
    irq_chk(1'b0);
    set_raw(5, 1'b1);
    irq_chk(1'b0);
    wr(8'h6e, 8'h01);
    cyc(3);
    rd_chk(8'h6e, 8'h03);
    irq_chk(1'b1);
    wr(8'h69, 8'h00);
  endtask

  // Both directions of the reference change must interrupt
  task automatic t_reference();
    wr(8'h69, 8'h02);
    set_raw(4, 1'b0);
    rd_chk(8'h6f, 8'h01);
    rd_chk(8'h6e, 8'h01);
    irq_chk(1'b0);
    wr(8'h6e, 8'h02);
    cyc(3);
    irq_chk(1'b1);
    set_raw(4, 1'b1);
    irq_chk(1'b0);
    wr(8'h6e, 8'h02);
    cyc(3);
    rd_chk(8'h6e, 8'h03);
    irq_chk(1'b1);
    wr(8'h69, 8'h00);
  endtask

  task automatic t_select_and_cal();
    @(posedge i_clock);
    raw[8:7] <= 2'b01;
    raw[6] <= 1'b1;
    cyc(8);
    rd_chk(8'h6d, 8'h73);
    rd_chk(8'h6f, 8'h07);
    @(posedge i_clock);
    raw[8:7] <= 2'b00;
    raw[6] <= 1'b0;
    cyc(8);
    rd_chk(8'h6d, 8'h33);
    rd_chk(8'h6f, 8'h03);
    irq_chk(1'b1);
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge i_clock);
    i_rst <= 1'b0;
    cyc(6);
    t_reset_and_access();
    t_lock_event(0, 5, 1'b1);
    t_lock_event(1, 4, 1'b1);
    t_lock_event(2, 0, 1'b1);
    t_lock_event(3, 1, 1'b1);
    t_lock_event(0, 5, 1'b0);
    t_lock_event(3, 1, 1'b0);
    t_two_pending();
    t_holdover();
    t_reference();
    t_select_and_cal();
    summarize();
  end

  // The whole sequence needs about 450 cycles
  initial begin
    #2000000;
    fails++;
    summarize();
  end
endmodule

`default_nettype wire
